// file: hw/mdc_lock_engine.sv
// lock engine: multiframe counter, window check, lock confirm, relock,
// and adjustment delay tracking.
// assumes the selected reference strobe is synchronous to mclk_in.
`timescale 1ns/1ps
module mdc_lock_engine
    import mdc_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire mdc_cfg_s cfg_in,
    input wire logic ref_in,
    output logic sref_out,
    output mdc_stat_s stat_out
);

    mdc_state_e state, next_state;
    logic ref_q, next_ref_q;
    logic [7:0] mf_cnt, next_mf_cnt;
    logic [3:0] lock_cnt, next_lock_cnt;
    logic [7:0] adj, next_adj;
    logic [7:0] dly_cnt, next_dly_cnt;
    logic first, next_first;
    logic start_early, next_start_early;
    logic start_late, next_start_late;
    logic sref, next_sref;
    logic [4:0] errs, next_errs;

    logic edge_seen, early, late, hit, mode_ok, en;
    logic se, sl;

    function automatic logic crit_hit(input logic [1:0] sel, input logic e, input logic l,
                                      input logic s_e, input logic s_l);
        unique case (sel)
            CRIT_BOTH: crit_hit = e & l;
            CRIT_LATE: crit_hit = l;
            CRIT_EARLY: crit_hit = e;
            CRIT_CROSS: crit_hit = (s_e & l) | (s_l & e);
        endcase
    endfunction : crit_hit

    always_comb begin
        en = cfg_in.sync_function_enable;
        mode_ok = (cfg_in.sync_protocol_mode == MODE_ALTERNATE)
                  || (cfg_in.sync_protocol_mode == MODE_SUBCLASS1);
        edge_seen = ref_in & ~ref_q;
        early = mf_cnt < cfg_in.window_low_time;
        late = ({1'b0, mf_cnt} + {1'b0, cfg_in.window_high_time})
               >= {1'b0, cfg_in.multiframe_period};
        se = first ? early : start_early;
        sl = first ? late : start_late;
        hit = crit_hit(cfg_in.lock_criterion_select, early, late, se, sl);

        next_ref_q = ref_in;
        next_state = state;
        next_lock_cnt = lock_cnt;
        next_adj = adj;
        next_dly_cnt = dly_cnt;
        next_first = first;
        next_start_early = start_early;
        next_start_late = start_late;
        next_errs = errs;
        next_errs[3] = (cfg_in.multiframe_period == 8'h00);

        // realign to the preset on the first edge of an acquisition
        if (!en) begin
            next_mf_cnt = 8'h00;
        end else if (edge_seen && state == MDC_ACQUIRE && first) begin
            next_mf_cnt = cfg_in.multiframe_preset;
        end else if ((mf_cnt + 8'h01) >= cfg_in.multiframe_period) begin
            next_mf_cnt = 8'h00;
        end else begin
            next_mf_cnt = mf_cnt + 8'h01;
        end
        next_sref = en & ~cfg_in.internal_ref_gen_disable & (next_mf_cnt == 8'h00);

        unique case (state)
            MDC_IDLE: begin
                if (en) begin
                    next_state = mode_ok ? MDC_ACQUIRE : MDC_MODE_ERR;
                    next_lock_cnt = 4'h0;
                    next_first = 1'b1;
                    next_adj = cfg_in.manual_adjust_delay;
                    next_dly_cnt = cfg_in.sync_counter_preset;
                    next_errs = 5'h00;
                end
            end
            MDC_ACQUIRE: begin
                if (edge_seen) begin
                    next_first = 1'b0;
                    if (first) begin
                        next_start_early = early;
                        next_start_late = late;
                    end
                    next_errs[1] = early & ~late;
                    next_errs[0] = late & ~early;
                    if (hit) begin
                        next_lock_cnt = lock_cnt + 4'h1;
                        if (lock_cnt >= cfg_in.lock_confirm_count) begin
                            next_state = MDC_LOCKED;
                        end
                    end else begin
                        next_lock_cnt = 4'h0;
                        next_first = 1'b1;
                        // auto mode steps the delay towards the window
                        if (!cfg_in.delay_manual_select && (early != late)) begin
                            if (dly_cnt == 8'h00 || (early && adj == ADJ_MIN)
                                || (late && adj == ADJ_MAX)) begin
                                next_errs[2] = 1'b1;
                            end else begin
                                next_adj = early ? adj - 8'h01 : adj + 8'h01;
                                next_dly_cnt = dly_cnt - 8'h01;
                            end
                        end
                    end
                end
            end
            MDC_LOCKED: begin
                if (edge_seen && !hit) begin
                    next_lock_cnt = 4'h0;
                    next_first = 1'b1;
                    next_errs[4] = 1'b1;
                    next_state = cfg_in.auto_relock ? MDC_ACQUIRE : MDC_LOCKOUT;
                end
            end
            MDC_LOCKOUT: begin
                next_state = MDC_LOCKOUT;
            end
            MDC_MODE_ERR: begin
                next_state = MDC_MODE_ERR;
            end
            default: begin
                next_state = MDC_IDLE;
            end
        endcase
        if (!en) begin
            next_state = MDC_IDLE;
        end else if (!mode_ok) begin
            next_state = MDC_MODE_ERR;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= MDC_IDLE;
            ref_q <= 1'b0;
            mf_cnt <= 8'h00;
            lock_cnt <= 4'h0;
            adj <= RST_MAN_ADJ;
            dly_cnt <= 8'h00;
            first <= 1'b1;
            start_early <= 1'b0;
            start_late <= 1'b0;
            sref <= 1'b0;
            errs <= 5'h00;
        end else begin
            state <= next_state;
            ref_q <= next_ref_q;
            mf_cnt <= next_mf_cnt;
            lock_cnt <= next_lock_cnt;
            adj <= next_adj;
            dly_cnt <= next_dly_cnt;
            first <= next_first;
            start_early <= next_start_early;
            start_late <= next_start_late;
            sref <= next_sref;
            errs <= next_errs;
        end
    end

    assign sref_out = sref;
    always_comb begin
        stat_out.adjust_delay = cfg_in.delay_manual_select ? cfg_in.manual_adjust_delay : adj;
        stat_out.repeat_err = errs[4];
        stat_out.period_err = errs[3];
        stat_out.adjust_err = errs[2];
        stat_out.early_err = errs[1];
        stat_out.late_err = errs[0];
        stat_out.active = en;
        stat_out.busy = (state == MDC_ACQUIRE);
        stat_out.state_err = (state == MDC_MODE_ERR);
        stat_out.state = state;
        stat_out.locked = (state == MDC_LOCKED);
        stat_out.lock_count = lock_cnt;
        stat_out.delay_count = dly_cnt;
    end

endmodule : mdc_lock_engine

// file: hw/mdc_sync_bank.sv
// multi-device sync register bank with reference input select and lock engine.
// assumes a serial port core gives decoded byte accesses on reg_,
// and reference pins synchronous to mclk_in.
`timescale 1ns/1ps
module mdc_sync_bank
    import mdc_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic east_reference_input_in,
    input wire logic west_reference_input_in,
    output logic internal_sref_out,
    output logic [7:0] adjust_delay_out,
    output logic signed [7:0] dataflow_offset_delay_out,
    output logic [7:0] pin_io_control_out,
    output logic [7:0] misc_control_a_out,
    output logic sync_locked_out
);

    logic [7:0] sync_main_control, next_sync_main_control;
    logic [7:0] sync_pin_io_control, next_sync_pin_io_control;
    logic [7:0] sync_misc_control_a, next_sync_misc_control_a;
    logic [7:0] manual_adjust_delay, next_manual_adjust_delay;
    logic [7:0] sync_misc_control_b, next_sync_misc_control_b;
    logic [7:0] dataflow_offset_delay, next_dataflow_offset_delay;
    logic [7:0] window_low_time, next_window_low_time;
    logic [7:0] window_high_time, next_window_high_time;
    logic [7:0] multiframe_period, next_multiframe_period;
    logic [7:0] multiframe_preset, next_multiframe_preset;
    logic [7:0] sync_counter_preset, next_sync_counter_preset;
    logic [7:0] rdata, next_rdata;
    logic [7:0] adj_q, next_adj_q;
    logic signed [7:0] offset_q, next_offset_q;
    logic locked_q, next_locked_q;

    mdc_cfg_s cfg;
    mdc_stat_s stat;
    logic ref_sel;

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = reg_wr_in && (reg_addr_in == a);
    endfunction : wr_hit

    function automatic logic [7:0] onehot8(input logic [2:0] sel);
        onehot8 = 8'h01 << sel;
    endfunction : onehot8

    // control register writes
    always_comb begin
        next_sync_main_control = wr_hit(ADDR_MAIN) ? reg_wdata_in : sync_main_control;
        next_sync_pin_io_control = wr_hit(ADDR_PIN_IO) ? reg_wdata_in : sync_pin_io_control;
        next_sync_misc_control_a = wr_hit(ADDR_MISC_A) ? reg_wdata_in : sync_misc_control_a;
        next_manual_adjust_delay = wr_hit(ADDR_MAN_ADJ) ? reg_wdata_in : manual_adjust_delay;
        next_sync_misc_control_b = wr_hit(ADDR_MISC_B) ? reg_wdata_in : sync_misc_control_b;
        next_dataflow_offset_delay = wr_hit(ADDR_OFFSET) ? reg_wdata_in
                                                         : dataflow_offset_delay;
        next_window_low_time = wr_hit(ADDR_WIN_LOW) ? reg_wdata_in : window_low_time;
        next_window_high_time = wr_hit(ADDR_WIN_HIGH) ? reg_wdata_in : window_high_time;
        next_multiframe_period = wr_hit(ADDR_MF_PERIOD) ? reg_wdata_in : multiframe_period;
        next_multiframe_preset = wr_hit(ADDR_MF_PRESET) ? reg_wdata_in : multiframe_preset;
        next_sync_counter_preset = wr_hit(ADDR_CNT_PRESET) ? reg_wdata_in
                                                           : sync_counter_preset;
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_main_control <= RST_MAIN;
            sync_pin_io_control <= RST_PIN_IO;
            sync_misc_control_a <= RST_MISC_A;
            manual_adjust_delay <= RST_MAN_ADJ;
            sync_misc_control_b <= RST_MISC_B;
            dataflow_offset_delay <= RST_OFFSET;
            window_low_time <= RST_WIN_LOW;
            window_high_time <= RST_WIN_HIGH;
            multiframe_period <= RST_MF_PERIOD;
            multiframe_preset <= RST_MF_PRESET;
            sync_counter_preset <= RST_CNT_PRESET;
        end else begin
            sync_main_control <= next_sync_main_control;
            sync_pin_io_control <= next_sync_pin_io_control;
            sync_misc_control_a <= next_sync_misc_control_a;
            manual_adjust_delay <= next_manual_adjust_delay;
            sync_misc_control_b <= next_sync_misc_control_b;
            dataflow_offset_delay <= next_dataflow_offset_delay;
            window_low_time <= next_window_low_time;
            window_high_time <= next_window_high_time;
            multiframe_period <= next_multiframe_period;
            multiframe_preset <= next_multiframe_preset;
            sync_counter_preset <= next_sync_counter_preset;
        end
    end

    // configuration fan-out to the engine
    always_comb begin
        cfg.lock_criterion_select = sync_main_control[MAIN_CRIT_LSB +: 2];
        cfg.delay_manual_select = sync_main_control[MAIN_MANUAL_BIT];
        cfg.internal_ref_gen_disable = sync_main_control[MAIN_SREF_DIS_BIT];
        cfg.sync_protocol_mode = sync_main_control[MAIN_MODE_LSB +: 2];
        cfg.sync_function_enable = sync_main_control[MAIN_ENABLE_BIT];
        cfg.auto_relock = sync_misc_control_b[MISCB_RELOCK_BIT];
        cfg.lock_confirm_count = sync_misc_control_b[MISCB_CONFIRM_LSB +: 4];
        cfg.manual_adjust_delay = manual_adjust_delay;
        cfg.window_low_time = window_low_time;
        cfg.window_high_time = window_high_time;
        cfg.multiframe_period = multiframe_period;
        cfg.multiframe_preset = multiframe_preset;
        cfg.sync_counter_preset = sync_counter_preset;
    end

    // a side switch while running shows as a possible false edge; switch while disabled
    assign ref_sel = sync_main_control[MAIN_SIDE_BIT] ? east_reference_input_in
                                                      : west_reference_input_in;

    mdc_lock_engine u_engine (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .cfg_in(cfg),
        .ref_in(ref_sel),
        .sref_out(internal_sref_out),
        .stat_out(stat)
    );

    // read mux; status means nothing until the engine has run
    always_comb begin
        next_rdata = rdata;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                ADDR_MAIN: next_rdata = sync_main_control;
                ADDR_PIN_IO: next_rdata = sync_pin_io_control;
                ADDR_MISC_A: next_rdata = sync_misc_control_a;
                ADDR_MAN_ADJ: next_rdata = manual_adjust_delay;
                ADDR_MISC_B: next_rdata = sync_misc_control_b;
                ADDR_OFFSET: next_rdata = dataflow_offset_delay;
                ADDR_WIN_LOW: next_rdata = window_low_time;
                ADDR_WIN_HIGH: next_rdata = window_high_time;
                ADDR_MF_PERIOD: next_rdata = multiframe_period;
                ADDR_MF_PRESET: next_rdata = multiframe_preset;
                ADDR_CNT_PRESET: next_rdata = sync_counter_preset;
                ADDR_CUR_ADJ: next_rdata = stat.adjust_delay;
                ADDR_ERR_STAT: next_rdata = {stat.repeat_err, 1'b0, stat.period_err,
                                             stat.adjust_err, stat.early_err,
                                             stat.late_err, 1'b0, stat.active};
                ADDR_STATE_STAT: next_rdata = {stat.busy, stat.state_err, 2'h0,
                                               stat.state};
                ADDR_LOCK_STAT: next_rdata = {stat.locked, 7'h00};
                ADDR_LOCK_CNT: next_rdata = {4'h0, stat.lock_count};
                ADDR_DELAY_CNT: next_rdata = stat.delay_count;
                ADDR_SAMPLE_EN: next_rdata = onehot8(stat.adjust_delay[2:0]);
                ADDR_PHASE_EN: next_rdata = {6'h00, stat.adjust_delay[4:3]};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_comb begin
        next_adj_q = stat.adjust_delay;
        next_offset_q = dataflow_offset_delay;
        next_locked_q = stat.locked;
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata <= 8'h00;
            adj_q <= RST_MAN_ADJ;
            offset_q <= RST_OFFSET;
            locked_q <= 1'b0;
        end else begin
            rdata <= next_rdata;
            adj_q <= next_adj_q;
            offset_q <= next_offset_q;
            locked_q <= next_locked_q;
        end
    end

    assign reg_rdata_out = rdata;
    assign adjust_delay_out = adj_q;
    assign dataflow_offset_delay_out = offset_q;
    assign pin_io_control_out = sync_pin_io_control;
    assign misc_control_a_out = sync_misc_control_a;
    assign sync_locked_out = locked_q;

endmodule : mdc_sync_bank

// file: pkg/mdc_pkg.sv
// sync bank package: register map, reset values, fields, states,
// and the structs between the bank and the lock engine.
// assumes one device clock domain with an asynchronous active-high reset.
package mdc_pkg;

    localparam logic [7:0] ADDR_MAIN = 8'ha0;
    localparam logic [7:0] ADDR_PIN_IO = 8'ha2;
    localparam logic [7:0] ADDR_MISC_A = 8'ha3;
    localparam logic [7:0] ADDR_MAN_ADJ = 8'ha4;
    localparam logic [7:0] ADDR_MISC_B = 8'ha6;
    localparam logic [7:0] ADDR_OFFSET = 8'ha7;
    localparam logic [7:0] ADDR_WIN_LOW = 8'ha8;
    localparam logic [7:0] ADDR_WIN_HIGH = 8'ha9;
    localparam logic [7:0] ADDR_MF_PERIOD = 8'haa;
    localparam logic [7:0] ADDR_MF_PRESET = 8'hab;
    localparam logic [7:0] ADDR_CNT_PRESET = 8'hac;
    localparam logic [7:0] ADDR_CUR_ADJ = 8'hb5;
    localparam logic [7:0] ADDR_ERR_STAT = 8'hb6;
    localparam logic [7:0] ADDR_STATE_STAT = 8'hb7;
    localparam logic [7:0] ADDR_LOCK_STAT = 8'hb8;
    localparam logic [7:0] ADDR_LOCK_CNT = 8'hba;
    localparam logic [7:0] ADDR_DELAY_CNT = 8'hbb;
    localparam logic [7:0] ADDR_SAMPLE_EN = 8'hbc;
    localparam logic [7:0] ADDR_PHASE_EN = 8'hbd;

    localparam logic [7:0] RST_MAIN = 8'he0;
    localparam logic [7:0] RST_PIN_IO = 8'h30;
    localparam logic [7:0] RST_MISC_A = 8'h10;
    localparam logic [7:0] RST_MAN_ADJ = 8'h80;
    localparam logic [7:0] RST_MISC_B = 8'h0f;
    localparam logic [7:0] RST_OFFSET = 8'h00;
    localparam logic [7:0] RST_WIN_LOW = 8'h0f;
    localparam logic [7:0] RST_WIN_HIGH = 8'h07;
    localparam logic [7:0] RST_MF_PERIOD = 8'h10;
    localparam logic [7:0] RST_MF_PRESET = 8'h04;
    localparam logic [7:0] RST_CNT_PRESET = 8'h02;

    // main register field positions
    localparam int MAIN_CRIT_LSB = 6;
    localparam int MAIN_MANUAL_BIT = 5;
    localparam int MAIN_SREF_DIS_BIT = 4;
    localparam int MAIN_SIDE_BIT = 3;
    localparam int MAIN_MODE_LSB = 1;
    localparam int MAIN_ENABLE_BIT = 0;
    // misc b field positions
    localparam int MISCB_RELOCK_BIT = 4;
    localparam int MISCB_CONFIRM_LSB = 0;

    localparam logic [1:0] CRIT_BOTH = 2'h0;
    localparam logic [1:0] CRIT_LATE = 2'h1;
    localparam logic [1:0] CRIT_EARLY = 2'h2;
    localparam logic [1:0] CRIT_CROSS = 2'h3;

    localparam logic [1:0] MODE_ALTERNATE = 2'h0;
    localparam logic [1:0] MODE_SUBCLASS1 = 2'h2;

    localparam logic [7:0] ADJ_MAX = 8'hff;
    localparam logic [7:0] ADJ_MIN = 8'h00;

    typedef enum logic [3:0] {
        MDC_IDLE = 4'h0,
        MDC_ACQUIRE = 4'h1,
        MDC_LOCKED = 4'h2,
        MDC_LOCKOUT = 4'h3,
        MDC_MODE_ERR = 4'h4
    } mdc_state_e;

    typedef struct packed {
        logic [1:0] lock_criterion_select;
        logic delay_manual_select;
        logic internal_ref_gen_disable;
        logic [1:0] sync_protocol_mode;
        logic sync_function_enable;
        logic auto_relock;
        logic [3:0] lock_confirm_count;
        logic [7:0] manual_adjust_delay;
        logic [7:0] window_low_time;
        logic [7:0] window_high_time;
        logic [7:0] multiframe_period;
        logic [7:0] multiframe_preset;
        logic [7:0] sync_counter_preset;
    } mdc_cfg_s;

    typedef struct packed {
        logic [7:0] adjust_delay;
        logic repeat_err;
        logic period_err;
        logic adjust_err;
        logic early_err;
        logic late_err;
        logic active;
        logic busy;
        logic state_err;
        logic [3:0] state;
        logic locked;
        logic [3:0] lock_count;
        logic [7:0] delay_count;
    } mdc_stat_s;

endpackage : mdc_pkg

// file: tb/mdc_ref_src.sv
// reference strobe source on east and west pins, one strobe per 16 cycles.
// assumes steady inputs across rising edges; idle pins sit low.
`timescale 1ns/1ps
module mdc_ref_src (
    input wire logic mclk_in,
    input wire logic run_in,
    input wire logic east_in,
    output logic east_out,
    output logic west_out
);
    logic [3:0] cnt = 4'h0;
    initial east_out = 1'b0;
    initial west_out = 1'b0;
    // only one pin strobes, so a side mix-up shows as a missing lock
    always @(posedge mclk_in) begin
        cnt <= run_in ? cnt + 4'h1 : 4'h0;
        east_out <= run_in && east_in && cnt == 4'hf;
        west_out <= run_in && !east_in && cnt == 4'hf;
    end
endmodule : mdc_ref_src

// file: tb/mdc_sync_bank_assertions.sv
// checker on the sync bank ports: reads, offset, delay, lock, strobe.
// assumes it is bound into every mdc_sync_bank instance.
`timescale 1ns/1ps
module mdc_sync_bank_chk
    import mdc_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic internal_sref_out,
    input wire logic [7:0] adjust_delay_out,
    input wire logic signed [7:0] dataflow_offset_delay_out,
    input wire logic sync_locked_out
);
    logic [7:0] sh_main, sh_man;
    logic [1:0] quiet;
    logic cfg_wr, unmapped;
    assign cfg_wr = reg_wr_in && (reg_addr_in inside {ADDR_MAIN, ADDR_MAN_ADJ});
    assign unmapped = !(reg_addr_in inside {[8'ha0:8'ha4], [8'ha6:8'hac], [8'hb5:8'hb8],
        [8'hba:8'hbd]});
    // judged after three quiet cycles so engine latency never trips them
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sh_main <= RST_MAIN;
            sh_man <= RST_MAN_ADJ;
            quiet <= 2'h0;
        end else begin
            sh_main <= (reg_wr_in && reg_addr_in == ADDR_MAIN) ? reg_wdata_in : sh_main;
            sh_man <= (reg_wr_in && reg_addr_in == ADDR_MAN_ADJ) ? reg_wdata_in : sh_man;
            quiet <= cfg_wr ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
        end
    end
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved");
    a_unmapped_zero: assert property (reg_rd_in && unmapped ##1 !reg_rd_in |=>
        reg_rdata_out == 8'h00) else $error("unmapped read");
    a_main_readback: assert property (reg_wr_in && reg_addr_in == ADDR_MAIN
        ##1 !reg_wr_in ##1 reg_rd_in && !reg_wr_in && reg_addr_in == ADDR_MAIN ##1 !reg_rd_in
        |=> reg_rdata_out == $past(reg_wdata_in, 4)) else $error("main readback");
    a_offset_copy: assert property (reg_wr_in && reg_addr_in == ADDR_OFFSET |=> ##1
        dataflow_offset_delay_out == $signed($past(reg_wdata_in, 2)))
        else $error("offset out");
    a_manual_follow: assert property (quiet == 2'h3 && sh_main[MAIN_MANUAL_BIT]
        |-> adjust_delay_out == sh_man) else $error("manual delay");
    a_sref_off: assert property (quiet == 2'h3 && sh_main[MAIN_SREF_DIS_BIT]
        |-> !internal_sref_out) else $error("strobe when off");
    a_lock_off: assert property (quiet == 2'h3 && !sh_main[MAIN_ENABLE_BIT]
        |-> !sync_locked_out) else $error("lock when off");
    a_bad_mode: assert property (quiet == 2'h3 && sh_main[1]
        |-> !sync_locked_out) else $error("unused mode lock");
    a_sref_pulse: assert property (internal_sref_out |=> !internal_sref_out)
        else $error("long strobe");
endmodule : mdc_sync_bank_chk
bind mdc_sync_bank mdc_sync_bank_chk u_mdc_sync_bank_chk (.mclk_in(mclk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .internal_sref_out(internal_sref_out),
    .adjust_delay_out(adjust_delay_out), .dataflow_offset_delay_out(dataflow_offset_delay_out),
    .sync_locked_out(sync_locked_out));

// file: tb/tb_top.sv
// bench for the sync bank: map, fields, offset, manual delay, lock, modes, strobe.
// assumes the bound checker and the strobe source model.
`timescale 1ns/1ps
module tb_top;
    import mdc_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic run = 1'b0;
    logic [7:0] rdata, adj, pio, misca, d;
    logic signed [7:0] offs;
    logic sref, locked, east, west;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    always #5 mclk_in = ~mclk_in;
    mdc_sync_bank u_mdc_sync_bank (.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .east_reference_input_in(east), .west_reference_input_in(west),
        .internal_sref_out(sref), .adjust_delay_out(adj), .dataflow_offset_delay_out(offs),
        .pin_io_control_out(pio), .misc_control_a_out(misca), .sync_locked_out(locked));
    mdc_ref_src u_mdc_ref_src (.mclk_in(mclk_in), .run_in(run), .east_in(1'b1),
        .east_out(east), .west_out(west));
    task chk(input logic [7:0] got, exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    task wr_reg(input logic [7:0] a, v);
        addr = a;
        wdata = v;
        wr = 1'b1;
        @(negedge mclk_in);
        wr = 1'b0;
        @(negedge mclk_in);
    endtask : wr_reg
    task rd_reg(input logic [7:0] a);
        addr = a;
        rd = 1'b1;
        @(negedge mclk_in);
        rd = 1'b0;
        @(negedge mclk_in);
        d = rdata;
    endtask : rd_reg
    task strobes(input int n);
        run = 1'b1;
        repeat (n * 16 + 4) @(negedge mclk_in);
        run = 1'b0;
    endtask : strobes
    task automatic t_map();
        logic [7:0] a[11] = '{ADDR_MAIN, ADDR_PIN_IO, ADDR_MISC_A, ADDR_MAN_ADJ, ADDR_MISC_B,
            ADDR_OFFSET, ADDR_WIN_LOW, ADDR_WIN_HIGH, ADDR_MF_PERIOD, ADDR_MF_PRESET,
            ADDR_CNT_PRESET};
        logic [7:0] v[11] = '{RST_MAIN, RST_PIN_IO, RST_MISC_A, RST_MAN_ADJ, RST_MISC_B,
            RST_OFFSET, RST_WIN_LOW, RST_WIN_HIGH, RST_MF_PERIOD, RST_MF_PRESET, RST_CNT_PRESET};
        chk(pio, RST_PIN_IO, "pin io reset");
        chk(misca, RST_MISC_A, "misc a reset");
        for (int i = 0; i < 11; i++) begin
            rd_reg(a[i]);
            chk(d, v[i], "reset value");
        end
        wr_reg(8'ha5, 8'h5a);
        rd_reg(8'ha5);
        chk(d, 8'h00, "unmapped read");
        wr_reg(ADDR_PIN_IO, 8'h25);
        rd_reg(ADDR_PIN_IO);
        chk(pio, 8'h25, "pin io copy");
        $display("t_map done");
    endtask : t_map
    task t_fields();
        // all criterion and mode codes, function off
        for (int i = 0; i < 4; i++) begin
            wr_reg(ADDR_MAIN, {i[1:0], 3'h4, i[1:0], 1'b0});
            rd_reg(ADDR_MAIN);
            chk(d, {i[1:0], 3'h4, i[1:0], 1'b0}, "main readback");
        end
        for (int i = 0; i < 3; i++) begin
            wr_reg(ADDR_OFFSET, 8'h7f + 8'(i));
            repeat (2) @(negedge mclk_in);
            chk(offs, 8'h7f + 8'(i), "offset out");
        end
        wr_reg(ADDR_MAN_ADJ, 8'h5a);
        repeat (3) @(negedge mclk_in);
        chk(adj, 8'h5a, "manual delay");
        $display("t_fields done");
    endtask : t_fields
    task t_lock();
        wr_reg(ADDR_WIN_LOW, 8'hff);
        wr_reg(ADDR_WIN_HIGH, 8'h10);
        wr_reg(ADDR_MISC_B, 8'h12);
        wr_reg(ADDR_MAIN, 8'h05);
        wr_reg(ADDR_MAN_ADJ, 8'h33);
        strobes(5);
        chk(8'(locked), 8'h00, "wrong side");
        chk(adj, 8'h5a, "auto delay");
        wr_reg(ADDR_MAIN, 8'h2d);
        strobes(2);
        chk(8'(locked), 8'h00, "early lock");
        strobes(3);
        chk(8'(locked), 8'h01, "no lock");
        rd_reg(ADDR_LOCK_STAT);
        chk(8'(d[7]), 8'h01, "lock status");
        wr_reg(ADDR_WIN_LOW, 8'h00);
        strobes(1);
        chk(8'(locked), 8'h00, "miss kept lock");
        wr_reg(ADDR_WIN_LOW, 8'hff);
        strobes(3);
        chk(8'(locked), 8'h01, "no relock");
        wr_reg(ADDR_MAIN, 8'h2c);
        repeat (3) @(negedge mclk_in);
        chk(8'(locked), 8'h00, "lock when off");
        $display("t_lock done");
    endtask : t_lock
    task t_modes();
        for (int i = 0; i < 2; i++) begin
            wr_reg(ADDR_MAIN, i == 0 ? 8'h2b : 8'h2f);
            strobes(5);
            chk(8'(locked), 8'h00, "unused mode lock");
            rd_reg(ADDR_STATE_STAT);
            chk(8'(d[6]), 8'h01, "mode error flag");
        end
        $display("t_modes done");
    endtask : t_modes
    task t_sref();
        logic [7:0] n;
        for (int i = 0; i < 2; i++) begin
            wr_reg(ADDR_MAIN, i == 0 ? 8'h3d : 8'h2d);
            repeat (3) @(negedge mclk_in);
            n = 8'h00;
            repeat (32) begin
                @(negedge mclk_in);
                n = n + {7'h0, sref === 1'b1};
            end
            chk(n, i == 0 ? 8'h00 : 8'h02, "strobe count");
        end
        $display("t_sref done");
    endtask : t_sref
    task close_out();
        $display("tests %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (5) @(negedge mclk_in);
        rst_in = 1'b0;
        @(negedge mclk_in);
        t_map();
        t_fields();
        t_lock();
        t_modes();
        t_sref();
        close_out();
    end
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            $display("[ERR] %0t run too long", $time);
            close_out();
        end
    end
endmodule : tb_top
